/* File: shift_pkg.sv */
package shift_pkg;

  // Chain and path widths
  localparam int unsigned STAGE_COUNT = 8;
  localparam int unsigned SYNC_DEPTH  = 2;
  localparam int unsigned BUF_DEPTH   = 2;
  localparam int unsigned BUF_PTR_W   = 1;
  localparam int unsigned BUF_CNT_W   = 2;

  // Reset and clear values, full count and step values
  localparam logic [STAGE_COUNT-1:0] STAGE_CLEAR   = 8'h00;
  localparam logic [SYNC_DEPTH-1:0]  SYNC_RESET    = 2'h0;
  localparam logic [BUF_PTR_W-1:0]   PTR_RESET     = 1'h0;
  localparam logic [BUF_CNT_W-1:0]   CNT_RESET     = 2'h0;
  localparam logic [BUF_CNT_W-1:0]   CNT_FULL      = 2'h2;
  localparam logic [BUF_PTR_W-1:0]   PTR_ONE       = 1'h1;
  localparam logic [BUF_CNT_W-1:0]   CNT_ONE       = 2'h1;

  // Core clock
  localparam int unsigned CORE_CLK_PERIOD_NS = 10;

  // Stage indices
  localparam int unsigned FIRST_STAGE = 0;
  localparam int unsigned LAST_STAGE  = STAGE_COUNT - 1;

  // Last synchroniser stage, the only one logic may read
  localparam int unsigned SYNC_OUT = SYNC_DEPTH - 1;

endpackage

/* File: pair_buffer.sv */
`timescale 1ns/100ps
`default_nettype none

module pair_buffer #(
  parameter int unsigned WIDTH = shift_pkg::STAGE_COUNT,
  parameter int unsigned DEPTH = shift_pkg::BUF_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0]                     mem_reg [DEPTH];
  logic [shift_pkg::BUF_PTR_W-1:0]      wr_ptr_reg;
  logic [shift_pkg::BUF_PTR_W-1:0]      rd_ptr_reg;
  logic [shift_pkg::BUF_CNT_W-1:0]      count_reg;
  logic [shift_pkg::BUF_CNT_W-1:0]      count_next;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (count_reg != shift_pkg::CNT_FULL);
  assign out_valid = (count_reg != shift_pkg::CNT_RESET);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign count_next = push && !pop ? count_reg + shift_pkg::CNT_ONE :
                      pop && !push ? count_reg - shift_pkg::CNT_ONE : count_reg;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= shift_pkg::PTR_RESET;
      rd_ptr_reg <= shift_pkg::PTR_RESET;
      count_reg  <= shift_pkg::CNT_RESET;
    end else begin
      wr_ptr_reg <= push ? wr_ptr_reg + shift_pkg::PTR_ONE : wr_ptr_reg;
      rd_ptr_reg <= pop ? rd_ptr_reg + shift_pkg::PTR_ONE : rd_ptr_reg;
      count_reg  <= count_next;
    end
  end

  no_overfill_a: assert property (@(posedge core_clk) disable iff (rst)
    count_reg <= shift_pkg::CNT_FULL)
    else $error("pair buffer count beyond depth");

endmodule

`default_nettype wire

/* File: serial_in_parallel_out_shifter.sv */
// Functional notes
// - Eight stages shift one place per rising clock edge
// - Either serial input low loads zero
// - One input high, other input sets first stage
// - Shift only on rising clock, sample inputs there
// - Low clear zeroes all stages at once
// - No edge, no clear: stages hold value
`timescale 1ns/100ps
`default_nettype none

module serial_in_parallel_out_shifter (
  input  wire logic                              core_clk,
  input  wire logic                              rst,
  input  wire logic                              shift_clk,
  input  wire logic                              serial_a,
  input  wire logic                              serial_b,
  input  wire logic                              async_clear_n,
  output logic      [shift_pkg::STAGE_COUNT-1:0] parallel_out,
  output logic                                   stage_one_out,
  output logic                                   last_stage_out,
  output logic                                   word_valid,
  input  wire logic                              word_ready,
  output logic      [shift_pkg::STAGE_COUNT-1:0] word_data,
  output logic                                   capture_ready,
  output logic                                   word_dropped
);

  // Entry gate: both serial inputs must be high to load a one
  function automatic logic gate_in(input logic a, input logic b);
    gate_in = a & b;
  endfunction

  // Chain advance toward the last stage
  function automatic logic [shift_pkg::STAGE_COUNT-1:0] advance(
    input logic [shift_pkg::STAGE_COUNT-1:0] chain,
    input logic                              entry
  );
    advance = {chain[shift_pkg::STAGE_COUNT-2:0], entry};
  endfunction

  logic [shift_pkg::SYNC_DEPTH-1:0]  clk_sync_reg;
  logic [shift_pkg::SYNC_DEPTH-1:0]  a_sync_reg;
  logic [shift_pkg::SYNC_DEPTH-1:0]  b_sync_reg;
  logic                              clk_prev_reg;
  logic [shift_pkg::STAGE_COUNT-1:0] stages_reg;
  logic [shift_pkg::STAGE_COUNT-1:0] stages_next;
  logic                              dropped_reg;
  logic                              buf_in_ready;

  // Same sync depth on clock and data keeps them aligned at the edge
  wire clk_seen  = clk_sync_reg[shift_pkg::SYNC_OUT];
  wire a_seen    = a_sync_reg[shift_pkg::SYNC_OUT];
  wire b_seen    = b_sync_reg[shift_pkg::SYNC_OUT];
  wire rise_edge = clk_seen && !clk_prev_reg;
  wire entry_bit = gate_in(a_seen, b_seen);

  assign stages_next = rise_edge ? advance(stages_reg, entry_bit) : stages_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clk_sync_reg <= shift_pkg::SYNC_RESET;
      a_sync_reg   <= shift_pkg::SYNC_RESET;
      b_sync_reg   <= shift_pkg::SYNC_RESET;
      clk_prev_reg <= 1'h0;
    end else begin
      clk_sync_reg <= {clk_sync_reg[shift_pkg::SYNC_OUT-1:0], shift_clk};
      a_sync_reg   <= {a_sync_reg[shift_pkg::SYNC_OUT-1:0], serial_a};
      b_sync_reg   <= {b_sync_reg[shift_pkg::SYNC_OUT-1:0], serial_b};
      clk_prev_reg <= clk_seen;
    end
  end

  // Clear acts without the core clock; its release is not synchronised,
  // so upstream must not release it near a shift clock rise
  always_ff @(posedge core_clk or posedge rst or negedge async_clear_n) begin
    if (rst) begin
      stages_reg <= shift_pkg::STAGE_CLEAR;
    end else if (!async_clear_n) begin
      stages_reg <= shift_pkg::STAGE_CLEAR;
    end else begin
      stages_reg <= stages_next;
    end
  end

  // Word lost only when downstream leaves both entries full
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dropped_reg <= 1'h0;
    end else begin
      dropped_reg <= rise_edge && async_clear_n && !buf_in_ready;
    end
  end

  assign parallel_out   = stages_reg;
  assign stage_one_out  = stages_reg[shift_pkg::FIRST_STAGE];
  assign last_stage_out = stages_reg[shift_pkg::LAST_STAGE];
  assign capture_ready  = buf_in_ready;
  assign word_dropped   = dropped_reg;

  // Each shifted word is offered downstream unless both entries are full; a stall keeps two words
  pair_buffer #(
    .WIDTH (shift_pkg::STAGE_COUNT),
    .DEPTH (shift_pkg::BUF_DEPTH)
  ) word_buf (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (rise_edge && async_clear_n),
    .in_ready  (buf_in_ready),
    .in_data   (stages_next),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word_data)
  );

  shift_move_a: assert property (@(posedge core_clk) disable iff (rst)
    (rise_edge && async_clear_n) ##1 async_clear_n
    |-> parallel_out[shift_pkg::STAGE_COUNT-1:1] == $past(parallel_out[shift_pkg::STAGE_COUNT-2:0]))
    else $error("chain did not advance by one stage");

  blocked_entry_a: assert property (@(posedge core_clk) disable iff (rst)
    (rise_edge && !(a_seen && b_seen)) |=> !stage_one_out)
    else $error("first stage not low with a serial input low");

  pass_entry_b_a: assert property (@(posedge core_clk) disable iff (rst)
    (rise_edge && a_seen) ##1 async_clear_n |-> stage_one_out == $past(b_seen))
    else $error("first stage does not follow second serial input");

  pass_entry_a_a: assert property (@(posedge core_clk) disable iff (rst)
    (rise_edge && b_seen) ##1 async_clear_n |-> stage_one_out == $past(a_seen))
    else $error("first stage does not follow first serial input");

  rise_timing_a: assert property (@(posedge core_clk) disable iff (rst)
    rise_edge |-> $past(shift_clk, 2) && !$past(shift_clk, 3))
    else $error("shift without a rising shift clock two cycles earlier");

  clear_force_a: assert property (@(posedge core_clk) disable iff (rst)
    !async_clear_n |-> parallel_out == shift_pkg::STAGE_CLEAR)
    else $error("stages not cleared while clear is low");

  hold_still_a: assert property (@(posedge core_clk) disable iff (rst)
    (!rise_edge && async_clear_n) ##1 async_clear_n |-> $stable(parallel_out))
    else $error("stages changed without a shift clock rise");

  parallel_view_a: assert property (@(posedge core_clk) disable iff (rst)
    stage_one_out == parallel_out[shift_pkg::FIRST_STAGE]
    && last_stage_out == parallel_out[shift_pkg::LAST_STAGE])
    else $error("end stage outputs disagree with parallel word");

  word_offer_a: assert property (@(posedge core_clk) disable iff (rst)
    (rise_edge && async_clear_n && capture_ready) |=> word_valid)
    else $error("shifted word not offered downstream");

  drop_flag_a: assert property (@(posedge core_clk) disable iff (rst)
    (rise_edge && async_clear_n && !capture_ready) |=> word_dropped)
    else $error("lost word not flagged");

  ones_shift_c: cover property (@(posedge core_clk) disable iff (rst)
    rise_edge && entry_bit ##1 stage_one_out);

  full_chain_c: cover property (@(posedge core_clk) disable iff (rst)
    last_stage_out && async_clear_n);

  clear_hit_c: cover property (@(posedge core_clk) disable iff (rst)
    (parallel_out != shift_pkg::STAGE_CLEAR) ##1 !async_clear_n);

  stall_full_c: cover property (@(posedge core_clk) disable iff (rst)
    !capture_ready && !word_ready);

  drop_seen_c: cover property (@(posedge core_clk) disable iff (rst)
    word_dropped);

  // Only the second flop of each synchroniser feeds logic
  clk_sync_a: assert property (@(posedge core_clk) disable iff (rst)
    1'h1 |=> clk_seen == $past(clk_sync_reg[shift_pkg::SYNC_OUT-1]))
    else $error("shift clock synchroniser skipped a stage");

  a_sync_a: assert property (@(posedge core_clk) disable iff (rst)
    1'h1 |=> a_seen == $past(a_sync_reg[shift_pkg::SYNC_OUT-1]))
    else $error("first serial synchroniser skipped a stage");

  b_sync_a: assert property (@(posedge core_clk) disable iff (rst)
    1'h1 |=> b_seen == $past(b_sync_reg[shift_pkg::SYNC_OUT-1]))
    else $error("second serial synchroniser skipped a stage");

  rise_single_a: assert property (@(posedge core_clk) disable iff (rst)
    rise_edge |=> !rise_edge)
    else $error("one shift clock rise seen twice");

  last_stage_a: assert property (@(posedge core_clk) disable iff (rst)
    (rise_edge && async_clear_n) ##1 async_clear_n
    |-> last_stage_out == $past(parallel_out[shift_pkg::LAST_STAGE-1]))
    else $error("last stage did not take its predecessor");

  clear_no_drop_a: assert property (@(posedge core_clk) disable iff (rst)
    (rise_edge && !async_clear_n) |=> !word_dropped)
    else $error("word flagged lost while clear held the chain");

  // Buffer side: words leave in order and stand until taken
  word_match_a: assert property (@(posedge core_clk) disable iff (rst)
    (rise_edge && async_clear_n && !word_valid) ##1 async_clear_n
    |-> word_data == parallel_out)
    else $error("offered word differs from shifted stages");

  // Head content is undefined while empty, so only a held head is compared
  word_stand_a: assert property (@(posedge core_clk) disable iff (rst)
    (word_valid && !word_ready) |=> word_valid && $stable(word_data))
    else $error("offered word changed before it was taken");

  full_ready_a: assert property (@(posedge core_clk) disable iff (rst)
    !capture_ready |-> word_valid)
    else $error("buffer refuses words while empty");

  drop_cause_a: assert property (@(posedge core_clk) disable iff (rst)
    word_dropped |-> $past(rise_edge && async_clear_n && !capture_ready))
    else $error("word flagged lost without a shift into a full buffer");

  valid_after_pop_a: assert property (@(posedge core_clk) disable iff (rst)
    (word_valid && word_ready && !capture_ready) |=> word_valid)
    else $error("second held word lost on pop");

  empty_after_pop_a: assert property (@(posedge core_clk) disable iff (rst)
    (word_valid && word_ready && capture_ready && !(rise_edge && async_clear_n)) |=> !word_valid)
    else $error("buffer still offers a word after its only word left");

endmodule

`default_nettype wire

/* File: upstream_model.sv */
`timescale 1ns/100ps
`default_nettype none

module upstream_model (
  input  wire logic core_clk,
  output logic      shift_clk,
  output logic      serial_a,
  output logic      serial_b
);
  initial begin
    shift_clk = 1'h0;
    serial_a  = 1'h0;
    serial_b  = 1'h0;
  end

  // Data steady two cycles each side of the rise; high and low two cycles each
  task automatic send(input logic a, input logic b);
    @(negedge core_clk);
    serial_a = a;
    serial_b = b;
    repeat (2) @(negedge core_clk);
    shift_clk = 1'h1;
    repeat (2) @(negedge core_clk);
    // Past hold time: show the inverse, never stale data
    serial_a  = ~a;
    serial_b  = ~b;
    shift_clk = 1'h0;
    repeat (2) @(negedge core_clk);
  endtask

  task automatic toggle(input int n);
    repeat (n) begin
      @(negedge core_clk);
      serial_a = ~serial_a;
      serial_b = serial_a;
    end
  endtask
endmodule

`default_nettype wire

/* File: serial_in_parallel_out_shifter_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module serial_in_parallel_out_shifter_tb_top;
  typedef logic [shift_pkg::STAGE_COUNT-1:0] word_t;
  logic       core_clk;
  logic       rst;
  logic       async_clear_n;
  logic       word_ready;
  wire logic  shift_clk;
  wire logic  serial_a;
  wire logic  serial_b;
  word_t      parallel_out;
  word_t      word_data;
  word_t      exp;
  logic       stage_one_out;
  logic       last_stage_out;
  logic       word_valid;
  logic       capture_ready;
  logic       word_dropped;
  int         failures;
  int         cmp_count;
  int         drops;
  // Columns: a, b, expected entry bit
  logic [2:0] rows [9] = '{3'h7, 3'h4, 3'h2, 3'h0, 3'h7, 3'h7, 3'h2, 3'h7, 3'h7};

  upstream_model up (.core_clk(core_clk), .shift_clk(shift_clk), .serial_a(serial_a), .serial_b(serial_b));

  serial_in_parallel_out_shifter dut (
    .core_clk(core_clk), .rst(rst), .shift_clk(shift_clk), .serial_a(serial_a), .serial_b(serial_b),
    .async_clear_n(async_clear_n), .parallel_out(parallel_out), .stage_one_out(stage_one_out),
    .last_stage_out(last_stage_out), .word_valid(word_valid), .word_ready(word_ready),
    .word_data(word_data), .capture_ready(capture_ready), .word_dropped(word_dropped)
  );

  initial begin
    core_clk = 1'h0;
    forever #(shift_pkg::CORE_CLK_PERIOD_NS / 2) core_clk = ~core_clk;
  end

  // Lost-word pulse lasts one cycle, so it is counted as it happens
  always @(posedge core_clk) begin
    if (word_dropped === 1'h1) drops++;
  end

  task automatic check(input string name, input word_t seen, input word_t expv);
    cmp_count++;
    if (seen !== expv) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", name, expv, seen);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic pop(input word_t w);
    int n;
    n = 0;
    // Let an edge pass so a back-to-back pop never re-raises ready at once
    @(negedge core_clk);
    while (word_valid !== 1'h1 && n < 8) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 8) begin
      failures++;
      print_verdict();
    end
    check("word_data", word_data, w);
    word_ready = 1'h1;
    @(negedge core_clk);
    word_ready = 1'h0;
  endtask

  initial begin
    rst = 1'h1;
    async_clear_n = 1'h1;
    word_ready = 1'h0;
    exp = shift_pkg::STAGE_CLEAR;
    repeat (16) @(negedge core_clk);
    check("reset parallel_out", parallel_out, exp);
    check("reset flags", {5'h00, word_valid, capture_ready, word_dropped}, 8'h02);
    rst = 1'h0;
    $display("test reset done");
    for (int i = 0; i < 9; i++) begin
      up.send(rows[i][2], rows[i][1]);
      exp = {exp[shift_pkg::LAST_STAGE-1:0], rows[i][0]};
      check("parallel_out", parallel_out, exp);
      check("stage_one_out", {7'h00, stage_one_out}, {7'h00, rows[i][0]});
      check("last_stage_out", {7'h00, last_stage_out}, {7'h00, exp[shift_pkg::LAST_STAGE]});
      pop(exp);
    end
    $display("test table done");
    up.toggle(6);
    check("hold", parallel_out, exp);
    $display("test hold done");
    @(negedge core_clk);
    async_clear_n = 1'h0;
    #1;
    check("clear at once", parallel_out, shift_pkg::STAGE_CLEAR);
    up.send(1'h1, 1'h1);
    check("clear held", parallel_out, shift_pkg::STAGE_CLEAR);
    check("no push in clear", {7'h00, word_valid}, 8'h00);
    async_clear_n = 1'h1;
    up.send(1'h1, 1'h1);
    exp = 8'h01;
    check("after clear", parallel_out, exp);
    pop(exp);
    $display("test clear done");
    up.send(1'h1, 1'h0);
    check("one held", {7'h00, capture_ready}, 8'h01);
    up.send(1'h1, 1'h1);
    check("full", {7'h00, capture_ready}, 8'h00);
    up.send(1'h1, 1'h1);
    check("drop pulse", word_t'(drops), 8'h01);
    check("stages on drop", parallel_out, 8'h0b);
    pop(8'h02);
    pop(8'h05);
    check("drained", {6'h00, word_valid, capture_ready}, 8'h01);
    $display("test buffer done");
    @(negedge core_clk);
    rst = 1'h1;
    #1;
    check("mid reset", parallel_out, shift_pkg::STAGE_CLEAR);
    $display("test mid reset done");
    print_verdict();
  end
endmodule

`default_nettype wire
